/* hw/agl_pkg.sv */
/*
  Shared constants, types and the frame check function of the angle output
  timing block. Assumes a 100 MHz core clock; every cycle count is derived here.
*/
package agl_pkg;
  // Core clock
  localparam int CLK_PERIOD_NS = 10;
  // Angle register refresh period and processing latency
  localparam int ANGLE_UPDATE_PERIOD_NS = 2000;
  localparam int RESPONSE_NS = 17000;
  localparam int UPD_CYC = ANGLE_UPDATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RESP_CYC = RESPONSE_NS / CLK_PERIOD_NS;
  // Depth of the latency line and the sampling phase that makes the age exact
  localparam int HIST_DEPTH = (RESP_CYC + UPD_CYC - 1) / UPD_CYC;
  localparam logic [7:0] SAMPLE_PHASE = 8'(HIST_DEPTH * UPD_CYC - RESP_CYC);
  localparam logic [7:0] REFRESH_PHASE = 8'h00;
  localparam logic [7:0] PHASE_LAST = 8'(UPD_CYC - 1);
  localparam logic [3:0] HIST_LAST = 4'(HIST_DEPTH - 1);
  // Self-test durations and power-on timing
  localparam int LOGIC_SELFTEST_DURATION_MS = 30;
  localparam int HALL_SELFTEST_DURATION_MS = 52;
  localparam int SPI_READY_US = 300;
  localparam int POWER_ON_DURATION_US = 1000;
  localparam int LBIST_CYC = LOGIC_SELFTEST_DURATION_MS * 1000000 / CLK_PERIOD_NS;
  localparam int HALLST_CYC = HALL_SELFTEST_DURATION_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SPI_READY_CYC = SPI_READY_US * 1000 / CLK_PERIOD_NS;
  localparam int POWER_ON_CYC = POWER_ON_DURATION_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W = 23;
  // SPI framing
  localparam int SPI_FRAME_BITS = 20;
  localparam int SPI_WORD_BITS = 16;
  localparam logic [4:0] SPI_CNT_MAX = 5'h1F;
  localparam logic [3:0] CRC_INIT = 4'hF;
  localparam logic [3:0] CRC_POLY = 4'h3;
  // SENT trigger delay
  localparam logic [7:0] SENT_TRIG_TICKS = 8'h07;
  // PWM duty mapping
  localparam int PWM_LO_PCT = 5;
  localparam int PWM_SPAN_PCT = 90;
  localparam int PWM_FULL_PCT = 100;
  localparam int ANGLE_STEPS = 4096;
  localparam logic [39:0] PWM_LO_TERM = 40'(PWM_LO_PCT * ANGLE_STEPS);
  localparam logic [39:0] PWM_SPAN_MUL = 40'(PWM_SPAN_PCT);
  localparam logic [39:0] PWM_DIV = 40'(PWM_FULL_PCT * ANGLE_STEPS);

  // SPI output formats
  typedef enum logic [1:0] {
    AGL_FMT_12_FLAGS = 2'b00,
    AGL_FMT_15 = 2'b01,
    AGL_FMT_20_CRC = 2'b10
  } agl_fmt_type;

  // SENT trigger modes
  typedef enum logic [1:0] {
    AGL_SENT_CONT = 2'b00,
    AGL_SENT_TRIG = 2'b01,
    AGL_SENT_SHARED = 2'b10
  } agl_sent_mode_type;

  // Power-up and self-test sequence
  typedef enum logic [2:0] {
    AGL_ST_LOAD = 3'b000,
    AGL_ST_LBIST = 3'b001,
    AGL_ST_HALL = 3'b010,
    AGL_ST_WAIT = 3'b011,
    AGL_ST_RUN = 3'b100
  } agl_state_type;

  // Four-bit check over a 16-bit word, MSB first
  function automatic logic [3:0] agl_crc4(input logic [15:0] d);
    logic [3:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = c[3] ^ d[i];
      c = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end
    return c;
  endfunction
endpackage

/* hw/agl_sync2.sv */
/*
  Two-flop level synchroniser, one bit per lane.
  Assumes inputs that may change at any time relative to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module agl_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // First and second stage
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } agl_sync_type;

  agl_sync_type st_q; // Registered state
  agl_sync_type st_d; // Next state

  // Second stage only reads the first
  always_comb begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end

  // Reset to the idle-high level of the lines it serves
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.s2;
endmodule
`default_nettype wire

/* hw/agl_pwm.sv */
/*
  PWM carrier generator with 5..95 percent duty mapping of a 12-bit angle.
  Assumes period_cyc is at least 20 and comes from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module agl_pwm (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [11:0] angle,
  input wire logic [19:0] period_cyc,
  output logic pwm_o,
  output logic pwm_oe
);
  // Carrier counter, captured period and high time, output level
  typedef struct packed {
    logic [19:0] cnt;
    logic [19:0] per;
    logic [19:0] hi;
    logic level;
  } agl_pwm_type;

  agl_pwm_type st_q; // Registered state
  agl_pwm_type st_d; // Next state
  logic [39:0] hi_full; // Full-width high time

  // Linear map of the angle onto the middle 90 percent
  assign hi_full = (40'(period_cyc) * (agl_pkg::PWM_LO_TERM + agl_pkg::PWM_SPAN_MUL * 40'(angle)))
    / agl_pkg::PWM_DIV;

  // Carrier period and duty
  always_comb begin
    st_d = st_q;
    if (!enable) begin
      st_d.cnt = 20'h00000;
      st_d.level = 1'b0;
    end else if (st_q.cnt == 20'h00000) begin
      // Angle captured at the rising edge only
      st_d.per = period_cyc;
      st_d.hi = hi_full[19:0];
      st_d.level = 1'b1;
      st_d.cnt = 20'h00001;
    end else begin
      // Held values keep the duty stable through the period
      st_d.level = st_q.cnt < st_q.hi;
      st_d.cnt = (st_q.cnt >= st_q.per - 20'h00001) ? 20'h00000 : st_q.cnt + 20'h00001;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Open drain: pull low while the level is low
  assign pwm_o = 1'b0;
  assign pwm_oe = enable & ~st_q.level;
endmodule
`default_nettype wire

/* hw/agl_angle_out.sv */
/*
  Angle output timing block: power-up sequence, self-test timing, angle
  register refresh with latency line, SPI frame capture and shift, PWM and
  SENT payload latching.
  Assumes raw_angle comes from the processing pipeline on clk, sclk is the
  host's SPI clock and stands still outside frames, and cs_n falls at least
  three clk periods before the first sclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module agl_angle_out #(
  parameter int LBIST_CYCLES = agl_pkg::LBIST_CYC,
  parameter int HALLST_CYCLES = agl_pkg::HALLST_CYC,
  parameter int SPI_READY_CYCLES = agl_pkg::SPI_READY_CYC,
  parameter int POWER_ON_CYCLES = agl_pkg::POWER_ON_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] raw_angle,
  input wire logic [3:0] err_flags,
  input wire logic [15:0] nvm_zero_offset,
  input wire logic nvm_lbist_at_power_up,
  input wire logic nvm_hall_st_at_power_up,
  input wire logic nvm_sent_wide,
  input wire logic shadow_zero_we,
  input wire logic [15:0] shadow_zero_data,
  input wire logic write_adr_we,
  input wire logic [7:0] write_adr_data,
  input wire logic lbist_req,
  input wire logic hall_st_req,
  input wire logic [1:0] spi_format,
  input wire logic sclk,
  input wire logic cs_n,
  output logic miso_o,
  output logic miso_oe,
  input wire logic pwm_enable,
  input wire logic [19:0] pwm_period_cyc,
  output logic pwm_o,
  output logic pwm_oe,
  input wire logic [1:0] sent_mode,
  input wire logic [7:0] sent_tick_cyc,
  input wire logic [7:0] sent_slot_ticks,
  input wire logic sent_line,
  input wire logic sent_busy,
  output logic sent_start,
  output logic [15:0] sent_payload,
  output logic [15:0] zero_offset,
  output logic [7:0] write_adr,
  output logic selftest_busy,
  output logic spi_ready,
  output logic angle_settled,
  output logic [15:0] angle_value
);
  // Core-domain state
  typedef struct packed {
    agl_pkg::agl_state_type state;
    logic [agl_pkg::CNT_W-1:0] cnt;
    logic hall_pend;
    logic ret_run;
    logic [7:0] phase;
    logic [3:0] wr_idx;
    logic [agl_pkg::HIST_DEPTH-1:0][15:0] hist;
    logic [15:0] zero;
    logic [7:0] wadr;
    logic sent_wide;
    logic [15:0] angle;
    logic [3:0] flags;
    logic [19:0] pub;
    logic spi_rdy;
    logic settled;
    logic line_prev;
    logic sent_wait;
    logic [7:0] tick_cnt;
    logic [8:0] ticks_left;
    logic sent_go;
    logic [15:0] sent_pl;
  } agl_core_type;

  // SPI-clock-domain state
  typedef struct packed {
    logic [4:0] cnt;
    logic [19:0] sh;
  } agl_spi_type;

  agl_core_type c_q; // Core registers
  agl_core_type c_d; // Core next state
  agl_spi_type s_q; // SPI registers
  agl_spi_type s_d; // SPI next state
  logic cs_n_sync; // Chip select on clk
  logic line_sync; // SENT line on clk
  logic [15:0] word16; // Flags plus angle word; fifteen angle bits without flags in the 15-bit format
  logic [19:0] frame; // Left-aligned SPI frame
  logic in_run; // Normal operation
  logic [8:0] sent_target; // Delay in ticks

  // Cross chip select and the SENT line into the core domain
  agl_sync2 #(.W(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .din({cs_n, sent_line}),
    .dout({cs_n_sync, line_sync})
  );

  // Build the SPI frame from the current angle register
  always_comb begin
    word16 = 16'h0000;
    frame = 20'h00000;
    case (spi_format)
      agl_pkg::AGL_FMT_15: begin
        // Fifteen bits, no flags
        word16 = {1'b0, c_q.angle[15:1]};
        frame = {word16, 4'h0};
      end
      agl_pkg::AGL_FMT_20_CRC: begin
        // Check bits close the long frame
        word16 = {c_q.flags, c_q.angle[15:4]};
        frame = {word16, agl_pkg::agl_crc4(word16)};
      end
      default: begin
        // Flags in the top nibble, twelve angle bits below
        word16 = {c_q.flags, c_q.angle[15:4]};
        frame = {word16, 4'h0};
      end
    endcase
  end

  assign in_run = c_q.state == agl_pkg::AGL_ST_RUN;
  assign sent_target = 9'(agl_pkg::SENT_TRIG_TICKS)
    + ((sent_mode == agl_pkg::AGL_SENT_SHARED) ? 9'(sent_slot_ticks) : 9'h000);

  // Core next-state logic
  always_comb begin
    c_d = c_q;
    c_d.sent_go = 1'b0;
    c_d.line_prev = line_sync;
    // Shadow writes take effect only until the next power-up
    if (shadow_zero_we) begin
      c_d.zero = shadow_zero_data;
    end
    if (write_adr_we) begin
      c_d.wadr = write_adr_data;
    end
    // Power-up and self-test sequence
    case (c_q.state)
      agl_pkg::AGL_ST_LOAD: begin
        // Reload the zero offset and SENT width from the non-volatile copy, clear the write address
        c_d.zero = nvm_zero_offset;
        c_d.sent_wide = nvm_sent_wide;
        c_d.wadr = 8'h00;
        c_d.hall_pend = nvm_hall_st_at_power_up;
        c_d.ret_run = 1'b0;
        c_d.cnt = '0;
        if (nvm_lbist_at_power_up) begin
          c_d.state = agl_pkg::AGL_ST_LBIST;
        end else if (nvm_hall_st_at_power_up) begin
          c_d.state = agl_pkg::AGL_ST_HALL;
        end else begin
          c_d.state = agl_pkg::AGL_ST_WAIT;
        end
      end
      agl_pkg::AGL_ST_LBIST: begin
        // Logic self-test time
        c_d.cnt = c_q.cnt + 1'b1;
        if (c_q.cnt == agl_pkg::CNT_W'(LBIST_CYCLES - 1)) begin
          c_d.cnt = '0;
          if (c_q.hall_pend) begin
            c_d.state = agl_pkg::AGL_ST_HALL;
          end else begin
            c_d.state = c_q.ret_run ? agl_pkg::AGL_ST_RUN : agl_pkg::AGL_ST_WAIT;
          end
        end
      end
      agl_pkg::AGL_ST_HALL: begin
        // Hall front-end self-test time
        c_d.cnt = c_q.cnt + 1'b1;
        if (c_q.cnt == agl_pkg::CNT_W'(HALLST_CYCLES - 1)) begin
          c_d.cnt = '0;
          c_d.hall_pend = 1'b0;
          c_d.state = c_q.ret_run ? agl_pkg::AGL_ST_RUN : agl_pkg::AGL_ST_WAIT;
        end
      end
      agl_pkg::AGL_ST_WAIT: begin
        // SPI opens early, the angle settles at the end of power-on
        c_d.cnt = c_q.cnt + 1'b1;
        if (c_q.cnt == agl_pkg::CNT_W'(SPI_READY_CYCLES - 1)) begin
          c_d.spi_rdy = 1'b1;
        end
        if (c_q.cnt == agl_pkg::CNT_W'(POWER_ON_CYCLES - 1)) begin
          c_d.spi_rdy = 1'b1;
          c_d.settled = 1'b1;
          c_d.cnt = '0;
          c_d.state = agl_pkg::AGL_ST_RUN;
        end
      end
      agl_pkg::AGL_ST_RUN: begin
        // Self-tests on user request
        c_d.ret_run = 1'b1;
        if (lbist_req) begin
          c_d.hall_pend = hall_st_req;
          c_d.state = agl_pkg::AGL_ST_LBIST;
        end else if (hall_st_req) begin
          c_d.hall_pend = 1'b1;
          c_d.state = agl_pkg::AGL_ST_HALL;
        end
      end
      default: begin
        c_d.state = agl_pkg::AGL_ST_LOAD;
      end
    endcase
    // Refresh phase counter
    c_d.phase = (c_q.phase == agl_pkg::PHASE_LAST) ? 8'h00 : c_q.phase + 8'h01;
    // Sample into the latency line at the offset phase
    if (c_q.phase == agl_pkg::SAMPLE_PHASE) begin
      c_d.hist[c_q.wr_idx] = raw_angle - c_q.zero;
      c_d.wr_idx = (c_q.wr_idx == agl_pkg::HIST_LAST) ? 4'h0 : c_q.wr_idx + 4'h1;
    end
    // Refresh with the oldest entry, exactly the latency old
    if (c_q.phase == agl_pkg::REFRESH_PHASE) begin
      c_d.angle = c_q.hist[c_q.wr_idx];
      c_d.flags = err_flags;
    end
    // Publish only while no frame is open, so the capture sees a still word
    if (cs_n_sync) begin
      c_d.pub = c_q.spi_rdy ? frame : 20'h00000;
    end
    // SENT trigger end is the rising edge of the line
    if (in_run && sent_mode != agl_pkg::AGL_SENT_CONT && !c_q.sent_wait
        && line_sync && !c_q.line_prev) begin
      c_d.sent_wait = 1'b1;
      c_d.tick_cnt = 8'h00;
      c_d.ticks_left = sent_target;
    end
    // Count whole ticks before the message may start
    if (c_q.sent_wait) begin
      c_d.tick_cnt = c_q.tick_cnt + 8'h01;
      if (c_q.tick_cnt >= sent_tick_cyc - 8'h01) begin
        c_d.tick_cnt = 8'h00;
        c_d.ticks_left = c_q.ticks_left - 9'h001;
        if (c_q.ticks_left <= 9'h001) begin
          c_d.sent_wait = 1'b0;
          c_d.sent_go = 1'b1;
        end
      end
    end
    // Free-running mode starts as soon as the framer is idle
    if (in_run && sent_mode == agl_pkg::AGL_SENT_CONT && !sent_busy && !c_q.sent_go) begin
      c_d.sent_go = 1'b1;
    end
    // Latch payload width chosen by the non-volatile field
    if (c_d.sent_go) begin
      c_d.sent_pl = c_q.sent_wide ? c_q.angle : {4'h0, c_q.angle[15:4]};
    end
  end

  // Core registers
  always_ff @(posedge clk) begin
    if (rst) begin
      c_q <= '0;
      c_q.state <= agl_pkg::AGL_ST_LOAD;
      c_q.line_prev <= 1'b1;
    end else begin
      c_q <= c_d;
    end
  end

  // SPI shift logic on the host clock
  always_comb begin
    s_d = s_q;
    if (s_q.cnt == 5'h00) begin
      // First edge of the frame takes the published word
      s_d.sh = c_q.pub;
    end else begin
      // Captured word shifts out unchanged by later refreshes
      s_d.sh = {s_q.sh[18:0], 1'b0};
    end
    if (s_q.cnt != agl_pkg::SPI_CNT_MAX) begin
      s_d.cnt = s_q.cnt + 5'h01;
    end
  end

  // Chip select ends the frame; the host clock stands still outside it
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign miso_o = s_q.sh[agl_pkg::SPI_FRAME_BITS-1];
  assign miso_oe = ~cs_n;

  // PWM carrier with its own angle capture
  agl_pwm u_pwm (
    .clk(clk),
    .rst(rst),
    .enable(pwm_enable & in_run),
    .angle(c_q.angle[15:4]),
    .period_cyc(pwm_period_cyc),
    .pwm_o(pwm_o),
    .pwm_oe(pwm_oe)
  );

  assign sent_start = c_q.sent_go;
  assign sent_payload = c_q.sent_pl;
  assign zero_offset = c_q.zero;
  assign write_adr = c_q.wadr;
  assign selftest_busy = (c_q.state == agl_pkg::AGL_ST_LBIST)
    || (c_q.state == agl_pkg::AGL_ST_HALL);
  assign spi_ready = c_q.spi_rdy;
  assign angle_settled = c_q.settled;
  assign angle_value = c_q.angle;
endmodule
`default_nettype wire

/* sim/agl_angle_out_asserts.sv */
/*
  Port-level timing checks of the angle output block.
  Assumes a bind from the testbench; every check runs on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module agl_angle_out_asserts #(
  parameter int SPI_READY_CYCLES = 1,
  parameter int POWER_ON_CYCLES = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic miso_oe,
  input wire logic [15:0] nvm_zero_offset,
  input wire logic [15:0] zero_offset,
  input wire logic [7:0] write_adr,
  input wire logic [15:0] angle_value,
  input wire logic [1:0] sent_mode,
  input wire logic sent_line,
  input wire logic sent_start,
  input wire logic angle_settled,
  input wire logic spi_ready,
  input wire logic pwm_enable,
  input wire logic [19:0] pwm_period_cyc,
  input wire logic pwm_oe,
  input wire logic selftest_busy
);
  // Cycles since reset release, saturating
  logic [15:0] up_cnt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      up_cnt_q <= 16'h0000;
    end else if (up_cnt_q != 16'hFFFF) begin
      up_cnt_q <= up_cnt_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Trigger edge seen while running in a triggered mode
  sequence s_trig;
    (sent_mode != 2'b00) && angle_settled && $rose(sent_line);
  endsequence
  // First cycle out of reset
  sequence s_release;
    $fell(rst);
  endsequence
  property p_oe;
    miso_oe == !cs_n;
  endproperty
  a_oe: assert property (p_oe) else $error("miso enable not tracking select");
  property p_sent_delay;
    s_trig |-> !sent_start [*8];
  endproperty
  a_sent_delay: assert property (p_sent_delay) else $error("sent start too early");
  property p_sent_pulse;
    sent_start |=> !sent_start;
  endproperty
  a_sent_pulse: assert property (p_sent_pulse) else $error("sent start too long");
  property p_angle_hold;
    $changed(angle_value) |=> $stable(angle_value) [*8];
  endproperty
  a_angle_hold: assert property (p_angle_hold) else $error("angle refreshed too soon");
  property p_pwm_off;
    (!pwm_enable || selftest_busy) |-> !pwm_oe;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm active while off");
  property p_pwm_head;
    $fell(pwm_oe) && (pwm_period_cyc >= 20'h000A0) |-> !pwm_oe [*8];
  endproperty
  a_pwm_head: assert property (p_pwm_head) else $error("pwm high phase too short");
  property p_ready_order;
    $rose(spi_ready) |-> !angle_settled && (up_cnt_q >= 16'(SPI_READY_CYCLES));
  endproperty
  a_ready_order: assert property (p_ready_order) else $error("spi ready early");
  property p_settle;
    $rose(angle_settled) |-> spi_ready && (up_cnt_q >= 16'(POWER_ON_CYCLES));
  endproperty
  a_settle: assert property (p_settle) else $error("angle settled early");
  property p_load;
    s_release |=> (zero_offset == $past(nvm_zero_offset)) && (write_adr == 8'h00);
  endproperty
  a_load: assert property (p_load) else $error("power-up load wrong");
endmodule
`default_nettype wire

/* sim/agl_host_model.sv */
/*
  Host side: SPI reader with its own 160 ns clock, and SENT trigger source.
  Assumes the device shifts on the rising sclk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module agl_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sent_line,
  input wire logic miso_o,
  input wire logic miso_oe
);
  // Idle: clock still, deselected, pulled-up trigger line
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sent_line = 1'b1;
  end
  // One frame of n clocks, sampled on falling edges; first bit into w[19]
  task automatic spi_read(input int n, output logic [19:0] w);
    w = 20'h00000;
    cs_n = 1'b0;
    #103;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      #80;
      sclk = 1'b0;
      // A released line does not hold its last value
      w[19 - i] = miso_oe ? miso_o : ~miso_o;
      #80;
    end
    cs_n = 1'b1;
    #200;
  endtask
  // Low trigger pulse; returns at its rising end
  task automatic sent_trigger();
    sent_line = 1'b0;
    #500;
    sent_line = 1'b1;
  endtask
endmodule
`default_nettype wire

/* sim/testbench.sv */
/*
  Self-checking bench of the angle output block with a host model.
  Assumes shortened self-test and power-on counts set below.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int LB = 50;
  localparam int HS = 80;
  localparam int SR = 600;
  localparam int PO = 2000;
  localparam int PWM_P = 400;
  localparam logic [15:0] NVM_ZERO = 16'h1234;
  localparam logic [3:0] FLAGS = 4'hA;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ramp_on = 1'b1;
  logic [15:0] cyc = 16'h0000;
  logic [15:0] raw_angle = 16'h0000;
  logic [15:0] shadow_zero_data = 16'h0000;
  logic [7:0] write_adr_data = 8'h00;
  logic shadow_zero_we = 1'b0, write_adr_we = 1'b0, lbist_req = 1'b0, hall_st_req = 1'b0;
  logic [1:0] spi_format = 2'h0, sent_mode = 2'h1;
  logic pwm_enable = 1'b0, sent_busy = 1'b1, wide = 1'b0;
  logic [19:0] pwm_period_cyc = 20'(PWM_P);
  logic [7:0] sent_tick_cyc = 8'h02, sent_slot_ticks = 8'h03;
  logic sclk, cs_n, sent_line, miso_o, miso_oe, pwm_o, pwm_oe, sent_start;
  logic selftest_busy, spi_ready, angle_settled;
  logic [15:0] sent_payload, zero_offset, angle_value, a0;
  logic [7:0] write_adr;
  logic [19:0] w;
  logic [31:0] got, e0, e1;
  int num_errors = 0, checked = 0, tcnt = 0, n, nb;
  logic [15:0] c0;
  agl_angle_out #(.LBIST_CYCLES(LB), .HALLST_CYCLES(HS), .SPI_READY_CYCLES(SR),
    .POWER_ON_CYCLES(PO)) dut (.clk(clk), .rst(rst), .raw_angle(raw_angle),
    .err_flags(FLAGS), .nvm_zero_offset(NVM_ZERO), .nvm_lbist_at_power_up(~wide),
    .nvm_hall_st_at_power_up(1'b1), .nvm_sent_wide(wide), .shadow_zero_we(shadow_zero_we),
    .shadow_zero_data(shadow_zero_data), .write_adr_we(write_adr_we),
    .write_adr_data(write_adr_data), .lbist_req(lbist_req), .hall_st_req(hall_st_req),
    .spi_format(spi_format), .sclk(sclk), .cs_n(cs_n), .miso_o(miso_o), .miso_oe(miso_oe),
    .pwm_enable(pwm_enable), .pwm_period_cyc(pwm_period_cyc), .pwm_o(pwm_o),
    .pwm_oe(pwm_oe), .sent_mode(sent_mode), .sent_tick_cyc(sent_tick_cyc),
    .sent_slot_ticks(sent_slot_ticks), .sent_line(sent_line), .sent_busy(sent_busy),
    .sent_start(sent_start), .sent_payload(sent_payload), .zero_offset(zero_offset),
    .write_adr(write_adr), .selftest_busy(selftest_busy), .spi_ready(spi_ready),
    .angle_settled(angle_settled), .angle_value(angle_value));
  agl_host_model host (.sclk(sclk), .cs_n(cs_n), .sent_line(sent_line), .miso_o(miso_o),
    .miso_oe(miso_oe));
  // Core clock
  always #5 clk = ~clk;
  // Cycle count, input ramp and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 16'h0001;
    if (ramp_on) begin
      raw_angle <= cyc;
    end
    tcnt++;
    if (tcnt == 40000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  // Expected SPI word, right-aligned
  function automatic logic [31:0] spi_exp(input logic [1:0] f, input logic [15:0] a);
    logic [3:0] c;
    logic [15:0] d;
    d = {FLAGS, a[15:4]};
    c = agl_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? agl_pkg::CRC_POLY : 4'h0);
    end
    case (f)
      2'b01: return {17'h0, a[15:1]};
      2'b10: return {12'h0, d, c};
      default: return {16'h0, d};
    endcase
  endfunction
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // Power-up self-tests, early frame refused, ready and settle times
    while (selftest_busy !== 1'b1) @(negedge clk);
    n = 0;
    while (selftest_busy === 1'b1) begin
      n++;
      @(negedge clk);
    end
    check(32'(n), 32'(LB + HS));
    c0 = cyc;
    host.spi_read(20, w);
    check({12'h0, w}, 32'h0);
    while (spi_ready !== 1'b1) @(negedge clk);
    n = int'(cyc - c0);
    check(32'(n >= SR - 2 && n <= SR + 2), 32'h1);
    while (angle_settled !== 1'b1) @(negedge clk);
    n = int'(cyc - c0);
    check(32'(n >= PO - 2 && n <= PO + 2), 32'h1);
    check({16'h0, zero_offset}, {16'h0, NVM_ZERO});
    check({24'h0, write_adr}, 32'h0);
    done("power_up");
    // Refresh period and age on a ramping input
    a0 = angle_value;
    while (angle_value === a0) @(negedge clk);
    a0 = angle_value;
    c0 = cyc;
    while (angle_value === a0) @(negedge clk);
    check(32'(cyc - c0), 32'(agl_pkg::UPD_CYC));
    n = int'(16'(cyc - angle_value - NVM_ZERO));
    check(32'(n >= agl_pkg::RESP_CYC && n <= agl_pkg::RESP_CYC + 4), 32'h1);
    done("refresh");
    // Every SPI format while the angle keeps refreshing
    for (int f = 0; f < 4; f++) begin
      @(posedge clk);
      spi_format <= 2'(f);
      repeat (4) @(negedge clk);
      a0 = angle_value;
      nb = (f == 2) ? 20 : 16;
      host.spi_read(nb, w);
      got = {12'h0, w} >> (20 - nb);
      e0 = spi_exp(2'(f), a0);
      e1 = spi_exp(2'(f), a0 + 16'(agl_pkg::UPD_CYC));
      check(got, (got === e1) ? e1 : e0);
    end
    done("spi_formats");
    // PWM high time at both ends of the angle range
    ramp_on <= 1'b0;
    pwm_enable <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      raw_angle <= NVM_ZERO + ((k == 1) ? 16'hFFFF : 16'h0000);
      repeat (agl_pkg::RESP_CYC + 2 * agl_pkg::UPD_CYC) @(negedge clk);
      while (pwm_oe !== 1'b1) @(negedge clk);
      while (pwm_oe !== 1'b0) @(negedge clk);
      n = 0;
      while (pwm_oe === 1'b0) begin
        n++;
        @(negedge clk);
      end
      nb = PWM_P * (agl_pkg::PWM_LO_PCT * agl_pkg::ANGLE_STEPS
        + agl_pkg::PWM_SPAN_PCT * k * 4095) / (agl_pkg::PWM_FULL_PCT * agl_pkg::ANGLE_STEPS);
      check({pwm_o, 31'(n)}, 32'(nb));
    end
    pwm_enable <= 1'b0;
    done("pwm");
    // Triggered and shared SENT start delay, then continuous mode
    for (int m = 1; m < 3; m++) begin
      @(posedge clk);
      sent_mode <= 2'(m);
      repeat (4) @(negedge clk);
      host.sent_trigger();
      n = 0;
      while (sent_start !== 1'b1 && n < 100) begin
        n++;
        @(negedge clk);
      end
      nb = (7 + (m - 1) * 3) * 2;
      check(32'(n >= nb && n <= nb + 6), 32'h1);
    end
    @(posedge clk);
    sent_mode <= 2'b00;
    sent_busy <= 1'b0;
    repeat (8) @(negedge clk);
    check({16'h0, sent_payload}, 32'h00000FFF);
    done("sent");
    // Shadow writes, then a second power-up discards them
    @(posedge clk);
    shadow_zero_data <= 16'h5555;
    shadow_zero_we <= 1'b1;
    write_adr_data <= 8'h3C;
    write_adr_we <= 1'b1;
    @(posedge clk);
    shadow_zero_we <= 1'b0;
    write_adr_we <= 1'b0;
    repeat (2) @(negedge clk);
    check({16'h0, zero_offset}, 32'h00005555);
    check({24'h0, write_adr}, 32'h0000003C);
    @(posedge clk);
    rst <= 1'b1;
    wide <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(negedge clk);
    check({16'h0, zero_offset}, {16'h0, NVM_ZERO});
    check({24'h0, write_adr}, 32'h0);
    while (angle_settled !== 1'b1) @(negedge clk);
    repeat (4) @(negedge clk);
    check({16'h0, sent_payload}, 32'h0000FFFF);
    done("repower");
    // Self-tests on request
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      lbist_req <= (r == 0);
      hall_st_req <= (r == 1);
      @(posedge clk);
      lbist_req <= 1'b0;
      hall_st_req <= 1'b0;
      while (selftest_busy !== 1'b1) @(negedge clk);
      n = 0;
      while (selftest_busy === 1'b1) begin
        n++;
        @(negedge clk);
      end
      check(32'(n), 32'((r == 0) ? LB : HS));
      repeat (PO + 50) @(negedge clk);
    end
    done("selftest_request");
    tally_and_finish();
  end
endmodule
bind agl_angle_out agl_angle_out_asserts #(.SPI_READY_CYCLES(SPI_READY_CYCLES),
  .POWER_ON_CYCLES(POWER_ON_CYCLES)) u_chk (.clk(clk), .rst(rst), .cs_n(cs_n),
  .miso_oe(miso_oe), .nvm_zero_offset(nvm_zero_offset), .zero_offset(zero_offset),
  .write_adr(write_adr), .angle_value(angle_value), .sent_mode(sent_mode),
  .sent_line(sent_line), .sent_start(sent_start), .angle_settled(angle_settled),
  .spi_ready(spi_ready), .pwm_enable(pwm_enable), .pwm_period_cyc(pwm_period_cyc),
  .pwm_oe(pwm_oe), .selftest_busy(selftest_busy));
`default_nettype wire
